/* logic/sync_sram_regs.svh */
`ifndef SYNC_SRAM_REGS_SVH
`define SYNC_SRAM_REGS_SVH
`define SRAM_ADDR_W  8
`define SRAM_DEPTH   256
`define SRAM_LANES   4
`define SRAM_LANE_W  9
`define SRAM_DATA_W  36
`define SRAM_BURST_W 2
`endif

/* logic/sync_sram_pkg.sv */
`default_nettype none
package sync_sram_pkg;
   typedef enum logic [1:0] {
      OP_IDLE  = 2'b00,
      OP_READ  = 2'b01,
      OP_WRITE = 2'b10
   } burst_op_t;
endpackage
`default_nettype wire

/* logic/sram_byte_lane.sv */
`include "sync_sram_regs.svh"
`default_nettype none
module sram_byte_lane (
   // Clock.
   input  wire logic                      i_sys_clk,
   // Write side.
   input  wire logic                      i_wr_en,
   input  wire logic [`SRAM_ADDR_W-1:0]   i_wr_addr,
   input  wire logic [`SRAM_LANE_W-1:0]   i_wr_data,
   // Read side.
   input  wire logic [`SRAM_ADDR_W-1:0]   i_rd_addr,
   output logic      [`SRAM_LANE_W-1:0]   o_rd_data
);
   logic [`SRAM_LANE_W-1:0] mem_ff [`SRAM_DEPTH];

   // The array holds no reset; its content is undefined until written.
   always_ff @(posedge i_sys_clk) begin
      if (i_wr_en) begin
         mem_ff[i_wr_addr] <= i_wr_data;
      end
   end

   assign o_rd_data = mem_ff[i_rd_addr];
endmodule // sram_byte_lane
`default_nettype wire

/* logic/sync_sram_port.sv */
`include "sync_sram_regs.svh"
`default_nettype none
module sync_sram_port (
   // Clock and reset.
   input  wire logic                      i_sys_clk,
   input  wire logic                      i_rstn,
   // Synchronous command inputs.
   input  wire logic                      i_clk_en_n,
   input  wire logic [`SRAM_ADDR_W-1:0]   i_addr,
   input  wire logic                      i_we_n,
   input  wire logic                      i_advance_not_load,
   input  wire logic                      i_chip_select_1_n,
   input  wire logic                      i_chip_select_2,
   input  wire logic                      i_chip_select_3_n,
   input  wire logic                      i_byte_lane0_wr_n,
   input  wire logic                      i_byte_lane1_wr_n,
   input  wire logic                      i_byte_lane2_wr_n,
   input  wire logic                      i_byte_lane3_wr_n,
   // Static configuration.
   input  wire logic                      i_flowthru_select,
   input  wire logic                      i_burst_order_select,
   // Asynchronous controls.
   input  wire logic                      i_out_en_n,
   input  wire logic                      i_sleep_request,
   // Data pins.
   input  wire logic [`SRAM_DATA_W-1:0]   i_dq,
   output logic      [`SRAM_DATA_W-1:0]   o_dq,
   output logic                           o_dq_oe_n
);
   typedef struct packed {
      sync_sram_pkg::burst_op_t      op;
      logic [`SRAM_ADDR_W-1:0]       base;
      logic [`SRAM_BURST_W-1:0]      cnt;
      logic [`SRAM_ADDR_W-1:0]       ra;
      logic                          rv;
      logic [`SRAM_ADDR_W-1:0]       wa1;
      logic [`SRAM_LANES-1:0]        wl1;
      logic                          wv1;
      logic [`SRAM_ADDR_W-1:0]       wa2;
      logic [`SRAM_LANES-1:0]        wl2;
      logic                          wv2;
      logic [`SRAM_DATA_W-1:0]       q;
      logic                          qv;
   } port_state_t;

   port_state_t                st_ff;
   port_state_t                nxt_st;
   logic                       chip_sel;
   logic [`SRAM_LANES-1:0]     lane_mask;
   logic [`SRAM_DATA_W-1:0]    rdata;
   logic [`SRAM_ADDR_W-1:0]    commit_addr;
   logic [`SRAM_LANES-1:0]     commit_lanes;
   logic                       commit_v;
   logic [`SRAM_LANES-1:0]     lane_we;
   logic                       drive;

   // Burst address from the loaded base and the step count.
   function automatic logic [`SRAM_ADDR_W-1:0] burst_addr(
      input logic [`SRAM_ADDR_W-1:0]  base,
      input logic [`SRAM_BURST_W-1:0] cnt,
      input logic                     order);
      logic [`SRAM_BURST_W-1:0] low;
      low = order ? (base[`SRAM_BURST_W-1:0] ^ cnt)
                  : (base[`SRAM_BURST_W-1:0] + cnt);
      burst_addr = {base[`SRAM_ADDR_W-1:`SRAM_BURST_W], low};
   endfunction

   // Sleep deselects asynchronously so a new command is never taken.
   assign chip_sel = !i_chip_select_1_n && i_chip_select_2 &&
                     !i_chip_select_3_n && !i_sleep_request;
   assign lane_mask = ~{i_byte_lane3_wr_n, i_byte_lane2_wr_n,
                        i_byte_lane1_wr_n, i_byte_lane0_wr_n};

   always_comb begin
      nxt_st = st_ff;
      // With clock enable high nothing moves, as if the edge never came.
      if (!i_clk_en_n) begin
         nxt_st.wa2 = st_ff.wa1;
         nxt_st.wl2 = st_ff.wl1;
         nxt_st.wv2 = st_ff.wv1;
         nxt_st.q   = rdata;
         nxt_st.qv  = st_ff.rv;
         nxt_st.rv  = 1'b0;
         nxt_st.wv1 = 1'b0;
         if (!i_advance_not_load) begin
            nxt_st.base = i_addr;
            nxt_st.cnt  = 2'h0;
            if (chip_sel) begin
               nxt_st.op = i_we_n ? sync_sram_pkg::OP_READ
                                  : sync_sram_pkg::OP_WRITE;
            end else begin
               nxt_st.op = sync_sram_pkg::OP_IDLE;
            end
         end else begin
            nxt_st.cnt = st_ff.cnt + 2'h1;
            if (i_sleep_request) begin
               nxt_st.op = sync_sram_pkg::OP_IDLE;
            end
         end
         // The order input is read live, so it must never change.
         unique case (nxt_st.op)
            sync_sram_pkg::OP_READ: begin
               nxt_st.rv = 1'b1;
               nxt_st.ra = burst_addr(nxt_st.base, nxt_st.cnt,
                                      i_burst_order_select);
            end
            sync_sram_pkg::OP_WRITE: begin
               nxt_st.wv1 = 1'b1;
               nxt_st.wl1 = lane_mask;
               nxt_st.wa1 = burst_addr(nxt_st.base, nxt_st.cnt,
                                       i_burst_order_select);
            end
            sync_sram_pkg::OP_IDLE: begin
               nxt_st.rv = 1'b0;
            end
            default: begin
               nxt_st.op = sync_sram_pkg::OP_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Pipelined mode writes at the third edge, flow-through at the second.
   assign commit_addr  = i_flowthru_select ? st_ff.wa1 : st_ff.wa2;
   assign commit_lanes = i_flowthru_select ? st_ff.wl1 : st_ff.wl2;
   assign commit_v     = i_flowthru_select ? st_ff.wv1 : st_ff.wv2;
   assign lane_we = {`SRAM_LANES{commit_v && !i_clk_en_n}} &
                    commit_lanes;

   genvar g;
   generate
      for (g = 0; g < `SRAM_LANES; g++) begin : g_lane
         sram_byte_lane u_lane (
            .i_sys_clk (i_sys_clk),
            .i_wr_en   (lane_we[g]),
            .i_wr_addr (commit_addr),
            .i_wr_data (i_dq[g*`SRAM_LANE_W +: `SRAM_LANE_W]),
            .i_rd_addr (st_ff.ra),
            .o_rd_data (rdata[g*`SRAM_LANE_W +: `SRAM_LANE_W])
         );
      end
   endgenerate

   // The pins leave the flop path on purpose: output enable and sleep must
   // cut the drivers at once, and flow-through bypasses the output register.
   assign drive = i_flowthru_select ? st_ff.rv : st_ff.qv;
   assign o_dq  = i_flowthru_select ? rdata : st_ff.q;
   assign o_dq_oe_n = !drive || i_out_en_n || i_sleep_request;

   logic read_cmd;
   logic write_cmd;
   assign read_cmd  = !i_clk_en_n && chip_sel && !i_advance_not_load &&
                      i_we_n;
   assign write_cmd = !i_clk_en_n && chip_sel && !i_advance_not_load &&
                      !i_we_n;

   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rstn);

   a_oe_override: assert property (
      i_out_en_n |-> o_dq_oe_n)
      else $error("data driven while output enable is off");

   a_sleep_drivers_off: assert property (
      i_sleep_request |-> o_dq_oe_n && !chip_sel)
      else $error("sleep did not cut drivers or selection");

   a_read_load_addr: assert property (
      read_cmd |=> st_ff.rv && st_ff.ra == $past(i_addr))
      else $error("read command did not load its address");

   a_pipe_read_data: assert property (
      st_ff.rv && !i_flowthru_select && !i_clk_en_n
      |=> st_ff.q == $past(rdata) && (i_out_en_n || i_sleep_request ||
          i_flowthru_select || (!o_dq_oe_n && o_dq == $past(rdata))))
      else $error("pipelined read data not presented one edge later");

   a_flow_read_data: assert property (
      i_flowthru_select && st_ff.rv && !i_out_en_n && !i_sleep_request
      |-> !o_dq_oe_n && o_dq == rdata)
      else $error("flow-through read not driven in capture cycle");

   a_suspend_hold: assert property (
      i_clk_en_n |=> st_ff == $past(st_ff))
      else $error("state moved while clock enable was off");

   a_deselect_idle: assert property (
      !i_clk_en_n && !i_advance_not_load && !chip_sel
      |=> !st_ff.rv && !st_ff.wv1)
      else $error("deselected load started an access");

   a_read_then_write: assert property (
      read_cmd ##1 write_cmd
      |=> st_ff.wv1 && st_ff.wl1 == $past(lane_mask) &&
          st_ff.wa1 == $past(i_addr))
      else $error("write after read was not taken");

   a_pipe_write_commit: assert property (
      write_cmd && !i_flowthru_select ##1 !i_clk_en_n ##1
      !i_clk_en_n && !i_flowthru_select
      |-> lane_we == $past(lane_mask, 2) && commit_addr == $past(i_addr, 2))
      else $error("pipelined write not committed at third edge");

   a_nop_write: assert property (
      write_cmd && lane_mask == 4'h0 && !i_flowthru_select ##1
      !i_clk_en_n ##1 !i_clk_en_n |-> lane_we == 4'h0)
      else $error("write with no byte enable changed memory");

   a_linear_step: assert property (
      !i_clk_en_n && i_advance_not_load && !i_sleep_request &&
      !i_burst_order_select && st_ff.op == sync_sram_pkg::OP_READ
      |=> st_ff.ra[1:0] == $past(st_ff.base[1:0] + st_ff.cnt + 2'h1))
      else $error("linear burst step wrong");

   a_inter_step: assert property (
      !i_clk_en_n && i_advance_not_load && !i_sleep_request &&
      i_burst_order_select && st_ff.op == sync_sram_pkg::OP_READ
      |=> st_ff.ra[1:0] == $past(st_ff.base[1:0] ^ (st_ff.cnt + 2'h1)))
      else $error("interleaved burst step wrong");

   // A burst keeps its base; only a load cycle may take a new address.
   a_burst_hold_base: assert property (
      !i_clk_en_n && i_advance_not_load
      |=> st_ff.base == $past(st_ff.base))
      else $error("burst advance changed the base address");

   a_load_clears_count: assert property (
      !i_clk_en_n && !i_advance_not_load
      |=> st_ff.cnt == 2'h0 && st_ff.base == $past(i_addr))
      else $error("load cycle did not restart the burst");

   a_write_load: assert property (
      write_cmd |=> st_ff.wv1 && !st_ff.rv && st_ff.wa1 == $past(i_addr) &&
      st_ff.wl1 == $past(lane_mask))
      else $error("write command not captured on its edge");

   // The commit stage follows the mode pin live, so both depths are checked.
   a_flow_write_commit: assert property (
      write_cmd && i_flowthru_select ##1 !i_clk_en_n && i_flowthru_select
      |-> lane_we == $past(lane_mask) && commit_addr == $past(i_addr))
      else $error("flow-through write not committed at second edge");

   a_suspend_no_write: assert property (
      i_clk_en_n |-> lane_we == 4'h0)
      else $error("memory written while clock enable was off");

   a_pipe_not_early: assert property (
      read_cmd && !i_flowthru_select && !st_ff.rv
      |=> o_dq_oe_n)
      else $error("pipelined read data driven one edge early");

   a_pipe_read_end: assert property (
      !i_flowthru_select && !i_clk_en_n && !st_ff.rv
      |=> o_dq_oe_n)
      else $error("pipelined read data held past its cycle");

   a_flow_drive_end: assert property (
      i_flowthru_select && !i_clk_en_n && !i_advance_not_load && !read_cmd
      |=> o_dq_oe_n)
      else $error("flow-through data driven without a read");

   // Sleep must also stop a running burst, not only refuse new loads.
   a_sleep_stops_burst: assert property (
      i_sleep_request && !i_clk_en_n
      |=> !st_ff.rv && !st_ff.wv1)
      else $error("sleep let an access start");

   c_pipe_read: cover property (
      read_cmd && !i_flowthru_select ##2 !o_dq_oe_n);
   c_flow_read: cover property (
      read_cmd && i_flowthru_select ##1 !o_dq_oe_n);
   c_read_write: cover property (read_cmd ##1 write_cmd);
   c_nop_write: cover property (write_cmd && lane_mask == 4'h0);
   c_burst_inter: cover property (
      read_cmd && i_burst_order_select ##1
      (!i_clk_en_n && i_advance_not_load)[*3]);
endmodule // sync_sram_port
`default_nettype wire

/* bench/sram_host_model.sv */
`default_nettype none
module sram_host_model (
   // Command bus as seen on the pins.
   input  wire logic        i_sys_clk,
   input  wire logic        i_clk_en_n,
   input  wire logic        i_we_n,
   input  wire logic        i_adv,
   input  wire logic [2:0]  i_cs,
   input  wire logic        i_flowthru,
   // Data handed over with each write command.
   input  wire logic [35:0] i_wdata,
   // Data bus toward the memory.
   output logic      [35:0] o_dq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [35:0] stage_ff = '0;
   logic        stage_vld_ff = 1'b0;
   wire  logic  take = !i_adv && !i_we_n && i_cs == 3'b010;
   initial o_dq = '0;
   // The bus flips when idle so stale data can never pass as a write.
   always @(posedge i_sys_clk) begin
      if (!i_clk_en_n) begin
         stage_vld_ff <= take && !i_flowthru;
         stage_ff     <= i_wdata;
         if (take && i_flowthru) o_dq <= i_wdata;
         else if (stage_vld_ff) o_dq <= stage_ff;
         else o_dq <= ~o_dq;
      end
   end
endmodule // sram_host_model
`default_nettype wire

/* bench/tb_top.sv */
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [2:0]  SEL = 3'b010;
   localparam logic [2:0]  OFF = 3'b101;
   localparam logic [35:0] D0 = 36'h0_0a0a_0a0a;
   localparam logic [35:0] D1 = 36'hf_1234_5678;
   localparam logic [35:0] D2 = 36'h5_a5a5_a5a5;
   localparam logic [35:0] D3 = 36'h3_c3c3_c3c3;
   localparam logic [35:0] D4 = 36'h9_8765_4321;
   localparam logic [35:0] D5 = 36'h6_0f0f_0f0f;
   localparam logic [35:0] D6 = 36'hc_fedc_ba98;
   localparam logic [35:0] X11 = {D1[35:27], D2[26:18], D1[17:9], D2[8:0]};
   logic        clk = 0, rstn = 0, ce_n = 0, we_n = 1, advance_not_load = 0;
   logic        ft = 0, bo = 0, oe_n = 0, slp = 0;
   logic [2:0]  cs = OFF;
   logic [3:0]  ln = 4'hf;
   logic [7:0]  a = '0;
   logic [35:0] wd = '0, dq, q, e [4];
   logic        q_oe_n;
   int          num_errors = 0, checks = 0, cycles = 0;
   sync_sram_port uut (.i_sys_clk(clk), .i_rstn(rstn), .i_clk_en_n(ce_n),
      .i_addr(a), .i_we_n(we_n), .i_advance_not_load(advance_not_load),
      .i_chip_select_1_n(cs[2]), .i_chip_select_2(cs[1]),
      .i_chip_select_3_n(cs[0]), .i_byte_lane0_wr_n(ln[0]),
      .i_byte_lane1_wr_n(ln[1]), .i_byte_lane2_wr_n(ln[2]),
      .i_byte_lane3_wr_n(ln[3]), .i_flowthru_select(ft),
      .i_burst_order_select(bo), .i_out_en_n(oe_n), .i_sleep_request(slp),
      .i_dq(dq), .o_dq(q), .o_dq_oe_n(q_oe_n));
   sram_host_model hm (.i_sys_clk(clk), .i_clk_en_n(ce_n), .i_we_n(we_n),
      .i_adv(advance_not_load), .i_cs(cs), .i_flowthru(ft), .i_wdata(wd), .o_dq(dq));
   always #20 clk = ~clk;
   task automatic finish_test();
      $display("checks=%0d errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // A hang past this ceiling is far beyond the roughly 50 cycles needed.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 500) begin
         $display("FAIL t=%0t run timed out", $time);
         num_errors++;
         finish_test();
      end
   end
   task automatic cyc(input logic w, v, input logic [2:0] c,
                      input logic [7:0] ad, input logic [3:0] l,
                      input logic [35:0] d);
      @(posedge clk);
      we_n <= w; advance_not_load <= v; cs <= c; a <= ad; ln <= l; wd <= d;
   endtask
   task automatic chk(input logic [35:0] x, input logic xoe);
      #1;
      checks++;
      if (q_oe_n !== xoe || (!xoe && q !== x)) begin
         num_errors++;
         $display("FAIL t=%0t dq=%h oe_n=%b", $time, q, q_oe_n);
      end
   endtask
   // Pipelined reads show one edge later than flow-through reads.
   task automatic burst(input logic [7:0] ad);
      int lag;
      lag = ft ? 0 : 1;
      cyc(1, 0, SEL, ad, 4'hf, '0);
      for (int k = 0; k < 4 + lag; k++) begin
         cyc(1, k < 3, (k < 3) ? SEL : OFF, ad, 4'hf, '0);
         if (k >= lag) chk(e[k-lag], 0);
      end
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1;
      cyc(0, 0, SEL, 8'h08, 4'h0, D5);
      cyc(0, 0, SEL, 8'h09, 4'h0, D6);
      cyc(0, 0, SEL, 8'h0a, 4'h0, D0);
      cyc(0, 0, SEL, 8'h0b, 4'h0, D1);
      cyc(0, 0, SEL, 8'h0b, 4'ha, D2);
      cyc(0, 0, SEL, 8'h0b, 4'hf, D3);
      for (int i = 0; i < 3; i++) begin
         cyc(0, 0, SEL ^ (3'b001 << i), 8'h0b, 4'h0, D3);
      end
      repeat (2) cyc(1, 0, OFF, 8'h00, 4'hf, '0);
      cyc(1, 0, SEL, 8'h0a, 4'hf, '0);
      cyc(0, 0, SEL, 8'h0c, 4'h0, D4);
      cyc(1, 0, SEL, 8'h0b, 4'hf, '0);
      chk(D0, 0);
      cyc(1, 0, OFF, 8'h00, 4'hf, '0);
      cyc(1, 0, SEL, 8'h0c, 4'hf, '0);
      chk(X11, 0);
      cyc(1, 0, OFF, 8'h00, 4'hf, '0);
      cyc(1, 0, OFF, 8'h00, 4'hf, '0);
      ce_n <= 1;
      chk(D4, 0);
      @(posedge clk);
      chk(D4, 0);
      @(posedge clk);
      oe_n <= 1;
      chk(D4, 1);
      @(posedge clk);
      oe_n <= 0;
      slp <= 1;
      chk(D4, 1);
      @(posedge clk);
      slp <= 0;
      ce_n <= 0;
      chk(D4, 0);
      cyc(1, 0, SEL, 8'h0a, 4'hf, '0);
      slp <= 1;
      cyc(1, 0, OFF, 8'h00, 4'hf, '0);
      slp <= 0;
      @(posedge clk);
      chk(D0, 1);
      e = '{D6, D0, X11, D5};
      burst(8'h09);
      $display("test pipelined done");
      // Mode pins move only while the device is held in reset.
      @(posedge clk);
      rstn <= 0;
      ft <= 1;
      bo <= 1;
      repeat (2) @(posedge clk);
      rstn <= 1;
      e = '{D6, D5, X11, D0};
      burst(8'h09);
      cyc(0, 0, SEL, 8'h0c, 4'h0, D3);
      cyc(1, 0, OFF, 8'h00, 4'hf, '0);
      cyc(1, 0, SEL, 8'h0c, 4'hf, '0);
      cyc(1, 0, OFF, 8'h00, 4'hf, '0);
      chk(D3, 0);
      $display("test flowthru done");
      finish_test();
   end
endmodule // tb_top
`default_nettype wire
